// ===== spd_page_pkg.sv
`default_nettype none
package spd_page_pkg;
  // ***************************************************************
  // address byte codes
  // ***************************************************************
  localparam logic [3:0] TYPE_MEMORY = 4'ha;
  localparam logic [3:0] TYPE_PAGE = 4'h6;
  localparam logic [7:0] CMD_SET_LOW = 8'h6c;
  localparam logic [7:0] CMD_SET_HIGH = 8'h6e;
  localparam logic [7:0] CMD_QUERY = 8'h6d;
  localparam int HALF_SEL_POS = 1;
  localparam int TYPE_LSB = 4;
  localparam int CS_LSB = 1;
  // ***************************************************************
  // counts and reset values
  // ***************************************************************
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] DONT_CARE_BYTES = 2'h2;
  localparam logic [4:0] RESET_ONES = 5'h12;
  localparam logic HALF_RESET = 1'b0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  // ***************************************************************
  // link state machine
  // ***************************************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK = 7'h04,
    ST_RX = 7'h08,
    ST_TX = 7'h10,
    ST_MACK = 7'h20,
    ST_PASS = 7'h40
  } link_state_e;
endpackage
`default_nettype wire

// ===== spd_half_select.sv
`default_nettype none
// Function
// - address byte: type, three selects, direction
// - type 1010 selects the memory array
// - type 0110 serves page and protect commands
// - select bits must equal the select pins
// - low bit one reads, zero writes
// - ack on match, else idle without ack
// - two 256 byte halves, four quadrants
// - half bit picks quadrants 0/1 or 2/3
// - 6Ch/6Eh set half, control byte acked
// - two dont-care bytes after set, not acked
// - 6Dh acked only when lower half selected
// - two dont-care bytes out after query
// - half select is zero after reset
// - bus software reset clears half select
// - ack drives data low in ninth clock
module spd_half_select (
  // system clock domain
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] word_addr,
  output logic [8:0] array_addr_q,
  output logic half_select_q,
  // link clock domain
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o_q,
  output logic sda_oe_n_q,
  output logic mem_select_q,
  output logic mem_read_q,
  // hard-wired select pins
  input wire logic chip_select_bit_hi,
  input wire logic chip_select_bit_mid,
  input wire logic chip_select_bit_lo
);
  import spd_page_pkg::*;
  // ***************************************************************
  // link side synchronisers
  // ***************************************************************
  logic rst_l1_q, rst_l_q, page_s1_q, page_s2_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [2:0] cs_s1_q, cs_s2_q;
  // every pin and the half bit pass two flops before use
  always_ff @(posedge link_clk)
  begin
    rst_l1_q <= rst;
    rst_l_q <= rst_l1_q;
    scl_s1_q <= scl_i;
    scl_s2_q <= scl_s1_q;
    scl_s3_q <= scl_s2_q;
    sda_s1_q <= sda_i;
    sda_s2_q <= sda_s1_q;
    sda_s3_q <= sda_s2_q;
    cs_s1_q <= {chip_select_bit_hi, chip_select_bit_mid, chip_select_bit_lo};
    cs_s2_q <= cs_s1_q;
    page_s1_q <= half_select_q;
    page_s2_q <= page_s1_q;
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  // start and stop are data edges while the clock is high
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // ***************************************************************
  // link state machine
  // ***************************************************************
  link_state_e st_q, st_d, after_q, after_d;
  logic [3:0] bits_q, bits_d, type_in;
  logic [7:0] shift_q, shift_d, byte_in;
  logic [1:0] left_q, left_d;
  logic [4:0] ones_q, ones_d;
  logic ack_q, ack_d, phase_q, phase_d, armed_q, armed_d;
  logic oe_n_d, msel_d, mrd_d, cs_ok;
  logic tog_q, tog_d, val_q, val_d;
  // fields of the byte as its last bit arrives
  assign byte_in = {shift_q[6:0], sda_s2_q}; // msb first
  assign type_in = byte_in[TYPE_LSB +: 4];
  assign cs_ok = byte_in[CS_LSB +: 3] == cs_s2_q;
  // next state of the link front end
  always_comb
  begin
    st_d = st_q;
    after_d = after_q;
    bits_d = bits_q;
    shift_d = shift_q;
    left_d = left_q;
    ones_d = ones_q;
    armed_d = armed_q;
    ack_d = ack_q;
    phase_d = phase_q;
    oe_n_d = sda_oe_n_q;
    msel_d = mem_select_q;
    mrd_d = mem_read_q;
    tog_d = tog_q;
    val_d = val_q;
    if (bus_start)
    begin
      st_d = ST_ADDR;
      bits_d = 4'h0;
      oe_n_d = 1'b1;
      msel_d = 1'b0;
      armed_d = ones_q >= RESET_ONES; // second start after the ones
      ones_d = 5'h00;
    end
    else if (bus_stop)
    begin
      st_d = ST_IDLE;
      oe_n_d = 1'b1;
      msel_d = 1'b0;
      armed_d = 1'b0;
      if (armed_q)
      begin
        tog_d = ~tog_q; // software reset clears the half
        val_d = HALF_RESET;
      end
    end
    else
    begin
      // run of ones since the last start, saturating
      if (scl_rise)
      begin
        armed_d = 1'b0;
        if (!sda_s2_q)
          ones_d = 5'h00;
        else if (ones_q < RESET_ONES)
          ones_d = ones_q + 5'h01;
      end
      unique case (st_q)
        ST_IDLE, ST_PASS: ; // only a start or stop leaves these
        ST_ADDR:
          if (scl_rise)
          begin
            shift_d = byte_in;
            bits_d = bits_q + 4'h1;
            if (bits_q == LAST_BIT)
            begin
              st_d = ST_ACK;
              phase_d = 1'b0;
              left_d = DONT_CARE_BYTES;
              bits_d = 4'h0;
              if (byte_in == CMD_SET_LOW || byte_in == CMD_SET_HIGH)
              begin
                ack_d = 1'b1;
                after_d = ST_RX;
                tog_d = ~tog_q;
                val_d = byte_in[HALF_SEL_POS];
              end
              else if (byte_in == CMD_QUERY)
              begin
                ack_d = ~page_s2_q; // ack means lower half
                after_d = ST_TX;
              end
              else if (cs_ok && (type_in == TYPE_MEMORY || type_in == TYPE_PAGE))
              begin
                ack_d = 1'b1;
                after_d = ST_PASS;
                msel_d = type_in == TYPE_MEMORY;
                mrd_d = byte_in[0];
              end
              else
                st_d = ST_IDLE; // no match: stay off the bus
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            if (!phase_q)
            begin
              oe_n_d = ~ack_q; // pull low for the ninth clock
              phase_d = 1'b1;
            end
            else
            begin
              oe_n_d = 1'b1;
              phase_d = 1'b0;
              st_d = after_q;
            end
          end
        ST_RX:
          if (scl_rise)
          begin
            bits_d = bits_q + 4'h1;
            if (bits_q == LAST_BIT)
            begin
              bits_d = 4'h0;
              st_d = ST_ACK;
              ack_d = 1'b0; // dont-care bytes are not acked
              phase_d = 1'b0;
              left_d = left_q - 2'h1;
              after_d = (left_q == 2'h1) ? ST_PASS : ST_RX;
            end
          end
        ST_TX:
          // bytes go out as all ones: line simply released
          if (scl_rise)
          begin
            bits_d = bits_q + 4'h1;
            if (bits_q == LAST_BIT)
              st_d = ST_MACK;
          end
        ST_MACK:
          if (scl_rise)
          begin
            bits_d = 4'h0;
            left_d = left_q - 2'h1;
            st_d = (left_q == 2'h1) ? ST_PASS : ST_TX;
          end
      endcase
    end
  end
  // link registers; reset arrives through its own synchroniser
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q)
    begin
      st_q <= ST_IDLE;
      after_q <= ST_IDLE;
      bits_q <= 4'h0;
      shift_q <= SHIFT_RESET;
      left_q <= 2'h0;
      ones_q <= 5'h00;
      armed_q <= 1'b0;
      ack_q <= 1'b0;
      phase_q <= 1'b0;
      sda_o_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      mem_select_q <= 1'b0;
      mem_read_q <= 1'b0;
      tog_q <= 1'b0;
      val_q <= HALF_RESET;
    end
    else
    begin
      st_q <= st_d;
      after_q <= after_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      left_q <= left_d;
      ones_q <= ones_d;
      armed_q <= armed_d;
      ack_q <= ack_d;
      phase_q <= phase_d;
      sda_o_q <= 1'b0; // open drain: only ever pulls low
      sda_oe_n_q <= oe_n_d;
      mem_select_q <= msel_d;
      mem_read_q <= mrd_d;
      tog_q <= tog_d;
      val_q <= val_d;
    end
  end

  // ***************************************************************
  // system side: half select and array address
  // ***************************************************************
  logic tog_s1_q, tog_s2_q, tog_s3_q, tog_s4_q;
  logic val_s1_q, val_s2_q, half_d;
  logic [8:0] addr_d;
  // toggle is delayed one stage more than the value so it has settled
  always_ff @(posedge clock)
  begin
    tog_s1_q <= tog_q;
    tog_s2_q <= tog_s1_q;
    tog_s3_q <= tog_s2_q;
    tog_s4_q <= tog_s3_q;
    val_s1_q <= val_q;
    val_s2_q <= val_s1_q;
  end
  // half follows each link event; address places it above the word
  always_comb
  begin
    half_d = half_select_q;
    if (tog_s3_q != tog_s4_q)
      half_d = val_s2_q;
    addr_d = {half_select_q, word_addr};
  end
  // lower half after reset, then registered every cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      half_select_q <= HALF_RESET; // lower half after power-up
      array_addr_q <= 9'h000;
    end
    else
    begin
      half_select_q <= half_d;
      array_addr_q <= addr_d;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_nack_release: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (st_q == ST_ACK && !ack_q) |-> sda_oe_n_q)
    else $error("line pulled during a nack slot");
  a_ack_pull: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (st_q == ST_ACK && phase_q && ack_q) |-> !sda_oe_n_q)
    else $error("ack slot without line pulled low");
  a_set_acked: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (st_q == ST_ADDR && scl_rise && !bus_start && !bus_stop && bits_q == LAST_BIT
      && (byte_in == CMD_SET_LOW || byte_in == CMD_SET_HIGH))
      |=> (st_q == ST_ACK && ack_q && after_q == ST_RX && tog_q != $past(tog_q)))
    else $error("set half command not acked");
  a_query_answer: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (st_q == ST_ADDR && scl_rise && !bus_start && !bus_stop && bits_q == LAST_BIT
      && byte_in == CMD_QUERY) |=> (ack_q == !$past(page_s2_q) && after_q == ST_TX))
    else $error("query answer does not match half select");
  a_mem_select: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (st_q == ST_ADDR && scl_rise && !bus_start && !bus_stop && bits_q == LAST_BIT
      && type_in == TYPE_MEMORY && cs_ok)
      |=> (mem_select_q && ack_q && mem_read_q == $past(sda_s2_q)))
    else $error("memory address byte not decoded");
  a_cs_mismatch: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (st_q == ST_ADDR && scl_rise && !bus_start && !bus_stop && bits_q == LAST_BIT
      && type_in == TYPE_MEMORY && !cs_ok) |=> (st_q == ST_IDLE && sda_oe_n_q))
    else $error("mismatched select bits were answered");
  a_dontcare_quiet: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (st_q == ST_RX || st_q == ST_TX || st_q == ST_MACK) |-> sda_oe_n_q)
    else $error("line pulled during dont-care bytes");
  a_soft_reset: assert property (@(posedge link_clk) disable iff (rst_l_q)
    (bus_stop && !bus_start && armed_q) |=> (tog_q != $past(tog_q) && val_q == HALF_RESET))
    else $error("software reset did not clear half select");
  a_half_update: assert property (@(posedge clock) disable iff (rst)
    (tog_s3_q != tog_s4_q) |=> (half_select_q == $past(val_s2_q)))
    else $error("half select missed a link event");
  a_array_addr: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> ##1 (array_addr_q == {$past(half_select_q), $past(word_addr)}))
    else $error("array address not formed from half and word");
endmodule
`default_nettype wire

// ===== i2c_host_model.sv
`default_nettype none
module i2c_host_model (
  // bench clock
  input wire logic clock,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv,
  // acknowledge report
  output logic ack_valid,
  output logic ack_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************
  // host bit and frame sequences
  // ************************************************
  logic s;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ack_valid = 1'b0;
    ack_seen = 1'b0;
  end
  // data moves one cycle after scl falls, so it never races the fall
  task automatic clk_bit(input logic b);
    @(posedge clock);
    sda_drv <= b;
    @(posedge clock);
    scl <= 1'b1;
    repeat (2) @(posedge clock);
    s = sda_line;
    scl <= 1'b0;
  endtask
  task automatic start();
    @(posedge clock);
    sda_drv <= 1'b1;
    @(posedge clock);
    scl <= 1'b1;
    repeat (2) @(posedge clock);
    sda_drv <= 1'b0;
    repeat (2) @(posedge clock);
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clock);
    sda_drv <= 1'b0;
    repeat (2) @(posedge clock);
    scl <= 1'b1;
    repeat (2) @(posedge clock);
    sda_drv <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i]); // msb first
    clk_bit(1'b1);
    ack_seen <= ~s;
    ack_valid <= 1'b1;
    @(posedge clock);
    ack_valid <= 1'b0;
  endtask
  task automatic recv_byte();
    repeat (8) clk_bit(1'b1);
    clk_bit(1'b1); // host never acks query bytes
  endtask
  task automatic soft_reset();
    start();
    repeat (18) clk_bit(1'b1); // eighteen ones
    @(posedge clock);
    scl <= 1'b1;
    repeat (2) @(posedge clock);
    sda_drv <= 1'b0; // start then stop, no scl rise between
    repeat (2) @(posedge clock);
    sda_drv <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import spd_page_pkg::*;
  // ************************************************
  // clocks, bus and design
  // ************************************************
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] word_addr = 8'h00;
  logic [2:0] pins = 3'h0;
  logic [8:0] array_addr_q;
  logic half_select_q, sda_o_q, sda_oe_n_q, mem_select_q, mem_read_q;
  logic scl, sda_drv, ack_valid, ack_seen, half_exp;
  wire logic sda_line;
  int bad_count = 0;
  int checks_done = 0;
  logic exp_q[$];
  logic [7:0] codes [4] = '{CMD_SET_HIGH, CMD_QUERY, CMD_SET_LOW, CMD_QUERY};
  always #50 clock = ~clock;
  initial #3 forever #7.5 link_clk = ~link_clk;
  // open drain with pull-up: low if either party pulls
  assign sda_line = sda_drv & (sda_oe_n_q | sda_o_q);
  spd_half_select dut_u (.clock(clock), .rst(rst), .word_addr(word_addr),
    .array_addr_q(array_addr_q), .half_select_q(half_select_q), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda_line), .sda_o_q(sda_o_q), .sda_oe_n_q(sda_oe_n_q),
    .mem_select_q(mem_select_q), .mem_read_q(mem_read_q), .chip_select_bit_hi(pins[2]),
    .chip_select_bit_mid(pins[1]), .chip_select_bit_lo(pins[0]));
  i2c_host_model host_u (.clock(clock), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv), .ack_valid(ack_valid), .ack_seen(ack_seen));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // each reported acknowledge is matched to the oldest note
  always @(posedge clock)
    if (ack_valid === 1'b1)
      check(9'(ack_seen), 9'(exp_q.pop_front()));
  task automatic frame(input logic [7:0] a, input logic ack);
    exp_q.push_back(ack);
    host_u.start();
    host_u.send_byte(a);
  endtask
  // half crosses domains, so wait for it under a bound
  task automatic check_half();
    word_addr <= 8'($urandom);
    for (int i = 0; i < 40 && half_select_q !== half_exp; i++)
      @(posedge clock);
    repeat (2) @(posedge clock);
    check(9'(half_select_q), 9'(half_exp));
    check(array_addr_q, {half_exp, word_addr});
  endtask
  task automatic set_half(input logic [7:0] code);
    half_exp = code[HALF_SEL_POS];
    frame(code, 1'b1);
    repeat (2) exp_q.push_back(1'b0);
    repeat (2) host_u.send_byte(8'($urandom));
    host_u.stop();
    check_half();
  endtask
  // ************************************************
  // test sequence
  // ************************************************
  initial
  begin
    void'($urandom(32'h22c9));
    half_exp = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    check_half();
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      pins <= 3'($urandom);
      repeat (4) @(posedge clock);
      frame({TYPE_MEMORY, pins, k[0]}, 1'b1);
      check(9'(mem_select_q), 9'h001);
      check(9'(mem_read_q), 9'(k[0]));
      host_u.stop();
      frame({TYPE_MEMORY, pins ^ 3'(k + 1), 1'b0}, 1'b0);
      host_u.stop();
      check(9'(mem_select_q), 9'h000);
    end
    frame({4'h3, pins, 1'b1}, 1'b0);
    host_u.stop();
    frame({TYPE_PAGE, pins, 1'b1}, 1'b1);
    host_u.stop();
    $display("test address done");
    foreach (codes[j])
    begin
      if (codes[j] == CMD_QUERY)
      begin
        frame(codes[j], ~half_exp);
        repeat (2) host_u.recv_byte();
        host_u.stop();
      end
      else
        set_half(codes[j]);
    end
    $display("test half select done");
    set_half(CMD_SET_HIGH);
    host_u.soft_reset();
    half_exp = 1'b0;
    check_half();
    $display("test soft reset done");
    summarize();
  end
  // watchdog well past the expected run of about 1300 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
